// ==== rtl/cej_exec.sv ====
// Purpose: Machine cycle and clock state sequencer for one instruction group.
// Assumes: Memory answers a read while RD_STROBE is high, sampled at T3.
// Notes:   Opcodes outside the group run as four-clock no-operations.
// Function
// - Fetch: address at T1, read and bump counter at T2, latch at T3.
// - Compare immediate sets flags from accumulator minus byte, keeps both.
// - Compare immediate: seven clocks, flags land at next fetch T2.
// - Decimal adjust adds six to low nibble above nine or aux carry.
// - Decimal adjust adds sixty when high nibble above nine, nine with low above nine, or carry.
// - Decimal adjust is four clocks, corrects at T4, sets all flags.
// - Register increment copies to operand latch, adds at T4, writes T5.
// - Memory increment reads pointer byte, adds, writes back: ten clocks.
// - Single increment and decrement set Z S P AC, keep carry.
// - Interrupt off clears the enable flop at T4, four clocks.
// - Interrupt on sets the enable flop at T4, four clocks.
// - Conditional jump picks zero, carry, parity or sign by field_a.
// - Conditional jump: ten clocks, target low byte first, then fetch.
`include "cej_consts.svh"
module cej_exec (
	// Clock and reset
	input  wire logic        CLK_SYS,
	input  wire logic        RST_N,
	// Memory bus
	output logic      [15:0] ADDR,
	input  wire logic [7:0]  DATA_IN,
	output logic      [7:0]  DATA_OUT,
	output logic             DATA_OE,
	output logic             RD_STROBE,
	output logic             WR_STROBE,
	output logic             SYNC,
	// Status
	output logic             ZERO_FLAG,
	output logic             SIGN_FLAG,
	output logic             PARITY_FLAG,
	output logic             CARRY_FLAG,
	output logic             AUX_CARRY_FLAG,
	output logic             IRQ_ENABLE
);
	cej_pkg::cej_tstate_e st_reg, st_next;
	cej_pkg::cej_mcycle_e mc_reg, mc_next;
	cej_pkg::cej_aluop_e  alu_op;
	logic [15:0] pc_reg, wz_reg, addr_reg;
	logic [7:0]  opcode_reg, act_reg, temp_reg, alu_reg, dout_reg;
	logic        jmp_go_reg, cmp_pend_reg, irq_en_reg;
	logic        z_reg, s_reg, p_reg, cy_reg, ac_reg;
	logic        oe_reg, rd_reg, wr_reg, sync_reg;
	logic [3:0]  icnt_reg;
	logic [7:0]  rda, rdb, alu_a, alu_res;
	logic        f_z, f_s, f_p, f_cy, f_ac;
	logic [3:0]  ra, rb, wa, wb;
	logic [7:0]  wda, wdb;
	logic        we_a, we_b;

	function automatic logic [3:0] pair_hi(input logic [1:0] pf);
		pair_hi = (pf == 2'b11) ? `CEJ_IDX_SPH : {1'b0, pf, 1'b0};
	endfunction

	function automatic logic op_incdec(input logic [7:0] op);
		op_incdec = (op[7:6] == 2'b00) && (op[2:1] == 2'b10);
	endfunction

	function automatic logic op_pair_dec(input logic [7:0] op);
		op_pair_dec = (op[7:6] == 2'b00) && (op[3:0] == 4'hb);
	endfunction

	function automatic logic [3:0] sel_ra(input logic [7:0] op);
		if (op_incdec(op) && op[5:3] == `CEJ_FLD_MEM)
			sel_ra = `CEJ_IDX_H;
		else if (op_incdec(op))
			sel_ra = {1'b0, op[5:3]};
		else if (op_pair_dec(op))
			sel_ra = pair_hi(op[5:4]);
		else
			sel_ra = `CEJ_IDX_A;
	endfunction

	function automatic logic [3:0] sel_rb(input logic [7:0] op);
		if (op_pair_dec(op))
			sel_rb = pair_hi(op[5:4]) | 4'h1;
		else
			sel_rb = `CEJ_IDX_L;
	endfunction

	// Opcode decode.
	wire        in_m1     = (mc_reg == cej_pkg::CEJ_M1);
	wire        in_m2     = (mc_reg == cej_pkg::CEJ_M2);
	wire        in_m3     = (mc_reg == cej_pkg::CEJ_M3);
	wire        at_t2     = (st_reg == cej_pkg::CEJ_T2);
	wire        at_t3     = (st_reg == cej_pkg::CEJ_T3);
	wire        at_t4     = (st_reg == cej_pkg::CEJ_T4);
	wire        at_t5     = (st_reg == cej_pkg::CEJ_T5);
	wire        is_cpi    = (opcode_reg == `CEJ_OP_CMP_IMM);
	wire        is_daa    = (opcode_reg == `CEJ_OP_DEC_ADJ);
	wire        is_di     = (opcode_reg == `CEJ_OP_IRQ_OFF);
	wire        is_ei     = (opcode_reg == `CEJ_OP_IRQ_ON);
	wire        is_dcx    = op_pair_dec(opcode_reg);
	wire        is_idm    = op_incdec(opcode_reg) &&
		(opcode_reg[5:3] == `CEJ_FLD_MEM);
	wire        is_idr    = op_incdec(opcode_reg) && !is_idm;
	wire        is_dec    = opcode_reg[0];
	wire        is_jcc    = (opcode_reg[7:6] == 2'b11) &&
		(opcode_reg[2:0] == 3'b010);
	wire [1:0]  field_a   = opcode_reg[5:4];
	wire        sense_bit = opcode_reg[3];
	wire [3:0]  flag_vec  = {s_reg, p_reg, cy_reg, z_reg};
	wire        field_a_hit  = (flag_vec[field_a] == sense_bit);
	wire        cmp_apply = in_m1 && at_t2 && cmp_pend_reg;
	wire        five_st   = is_idr || is_dcx;
	wire        multi_mc  = is_cpi || is_idm || is_jcc;
	wire [15:0] pair_val  = {rda, rdb};
	wire [15:0] pair_dec  = pair_val - 16'h0001;
	wire        wz_lo_ld  = in_m2 && at_t3 && is_jcc;
	wire        wz_hi_ld  = in_m3 && at_t3 && is_jcc;
	wire [15:0] wz_next   = {wz_hi_ld ? DATA_IN : wz_reg[15:8],
		wz_lo_ld ? DATA_IN : wz_reg[7:0]};
	wire        fl_load   = cmp_apply || (in_m1 && at_t4 && is_daa) ||
		(in_m1 && at_t5 && is_idr) || (in_m2 && at_t3 && is_idm);
	wire        wr_cyc    = (mc_next == cej_pkg::CEJ_M3) && is_idm;
	wire        enter_t1  = (st_next == cej_pkg::CEJ_T1);
	wire        bus_st    = (st_next == cej_pkg::CEJ_T2) ||
		(st_next == cej_pkg::CEJ_T3);
	wire        new_fetch = enter_t1 && (mc_next == cej_pkg::CEJ_M1);
	// A jump target is only pending on the way out of the third cycle.
	wire [15:0] addr_next = (mc_next == cej_pkg::CEJ_M1) ?
		(jmp_go_reg ? wz_next : pc_reg) :
		(is_idm ? pair_val : pc_reg);

	// Register reads: during T3 of fetch the opcode is still on DATA_IN.
	assign ra = (in_m1 && at_t3) ? sel_ra(DATA_IN) : sel_ra(opcode_reg);
	assign rb = (in_m1 && at_t3) ? sel_rb(DATA_IN) : sel_rb(opcode_reg);

	// Register writes.
	assign we_a = (in_m1 && at_t4 && is_daa) ||
		(in_m1 && at_t5 && (is_idr || is_dcx));
	assign wa   = is_daa ? `CEJ_IDX_A :
		(is_dcx ? pair_hi(field_a) : {1'b0, opcode_reg[5:3]});
	assign wda  = is_daa ? alu_res : (is_dcx ? pair_dec[15:8] : alu_reg);
	assign we_b = in_m1 && at_t5 && is_dcx;
	assign wb   = pair_hi(field_a) | 4'h1;
	assign wdb  = pair_dec[7:0];

	// Arithmetic operand and operation selection.
	assign alu_a  = cmp_apply ? act_reg :
		(in_m2 ? DATA_IN : (at_t4 ? rda : temp_reg));
	assign alu_op = cmp_apply ? cej_pkg::CEJ_ALU_CMP :
		(is_daa ? cej_pkg::CEJ_ALU_DAA :
		(is_dec ? cej_pkg::CEJ_ALU_DEC : cej_pkg::CEJ_ALU_INC));

	cej_regfile #(.DW(8), .N(10)) u_regs (
		.clk     (CLK_SYS),
		.rst_n   (RST_N),
		.ra      (ra),
		.rb      (rb),
		.rda_reg (rda),
		.rdb_reg (rdb),
		.we_a    (we_a),
		.wa      (wa),
		.wda     (wda),
		.we_b    (we_b),
		.wb      (wb),
		.wdb     (wdb)
	);

	cej_alu u_alu (
		.op    (alu_op),
		.a     (alu_a),
		.b     (temp_reg),
		.cy_in (cy_reg),
		.ac_in (ac_reg),
		.res   (alu_res),
		.z     (f_z),
		.s     (f_s),
		.p     (f_p),
		.cy    (f_cy),
		.ac    (f_ac)
	);

	// Clock state and machine cycle sequencing.
	always_comb begin
		st_next = st_reg;
		mc_next = mc_reg;
		unique case (st_reg)
			cej_pkg::CEJ_T1: st_next = cej_pkg::CEJ_T2;
			cej_pkg::CEJ_T2: st_next = cej_pkg::CEJ_T3;
			cej_pkg::CEJ_T3: begin
				if (in_m1) begin
					st_next = cej_pkg::CEJ_T4;
				end else begin
					st_next = cej_pkg::CEJ_T1;
					mc_next = (in_m2 && !is_cpi) ? cej_pkg::CEJ_M3 :
						cej_pkg::CEJ_M1;
				end
			end
			cej_pkg::CEJ_T4: begin
				st_next = five_st ? cej_pkg::CEJ_T5 : cej_pkg::CEJ_T1;
				mc_next = (!five_st && multi_mc) ? cej_pkg::CEJ_M2 :
					cej_pkg::CEJ_M1;
			end
			cej_pkg::CEJ_T5: begin
				st_next = cej_pkg::CEJ_T1;
				mc_next = cej_pkg::CEJ_M1;
			end
			default: begin
				st_next = cej_pkg::CEJ_T1;
				mc_next = cej_pkg::CEJ_M1;
			end
		endcase
	end

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			st_reg   <= cej_pkg::CEJ_T1;
			mc_reg   <= cej_pkg::CEJ_M1;
			icnt_reg <= 4'h0;
		end else begin
			st_reg   <= st_next;
			mc_reg   <= mc_next;
			icnt_reg <= new_fetch ? 4'h0 : icnt_reg + 4'h1;
		end
	end

	// Bus pins, all registered; address and strobes one state ahead.
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			addr_reg <= `CEJ_PC_RST;
			dout_reg <= 8'h00;
			rd_reg   <= 1'b0;
			wr_reg   <= 1'b0;
			oe_reg   <= 1'b0;
			sync_reg <= 1'b0;
		end else begin
			if (enter_t1)
				addr_reg <= addr_next;
			dout_reg <= alu_reg;
			rd_reg   <= bus_st && !wr_cyc;
			wr_reg   <= bus_st && wr_cyc;
			oe_reg   <= bus_st && wr_cyc;
			sync_reg <= enter_t1;
		end
	end

	// Program counter and jump target.
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			pc_reg     <= `CEJ_PC_RST;
			wz_reg     <= 16'h0000;
			jmp_go_reg <= 1'b0;
		end else begin
			wz_reg <= wz_next;
			if (in_m1 && at_t2)
				pc_reg <= (jmp_go_reg ? wz_reg : pc_reg) + 16'h0001;
			else if (at_t2 && !is_idm)
				pc_reg <= pc_reg + 16'h0001;
			if (in_m1 && at_t4)
				jmp_go_reg <= is_jcc && field_a_hit;
			else if (in_m1 && at_t2)
				jmp_go_reg <= 1'b0;
		end
	end

	// Opcode, accumulator hold and operand latches.
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			opcode_reg   <= 8'h00;
			act_reg      <= 8'h00;
			temp_reg     <= 8'h00;
			alu_reg      <= 8'h00;
			cmp_pend_reg <= 1'b0;
		end else begin
			if (in_m1 && at_t3)
				opcode_reg <= DATA_IN;
			if (in_m1 && at_t4 && is_cpi)
				act_reg <= rda;
			if (in_m1 && at_t4 && is_idr) begin
				temp_reg <= rda;
				alu_reg  <= alu_res;
			end else if (in_m2 && at_t3 && (is_cpi || is_idm)) begin
				temp_reg <= DATA_IN;
				alu_reg  <= alu_res;
			end
			// The compare finishes inside the following fetch cycle.
			if (in_m2 && at_t3 && is_cpi)
				cmp_pend_reg <= 1'b1;
			else if (cmp_apply)
				cmp_pend_reg <= 1'b0;
		end
	end

	// Status flags and interrupt enable.
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			{z_reg, s_reg, p_reg, cy_reg, ac_reg} <= 5'h00;
			irq_en_reg <= 1'b0;
		end else begin
			if (fl_load) begin
				{z_reg, s_reg, p_reg} <= {f_z, f_s, f_p};
				cy_reg <= f_cy;
				ac_reg <= f_ac;
			end
			if (in_m1 && at_t4 && is_di)
				irq_en_reg <= 1'b0;
			else if (in_m1 && at_t4 && is_ei)
				irq_en_reg <= 1'b1;
		end
	end

	assign ADDR           = addr_reg;
	assign DATA_OUT       = dout_reg;
	assign DATA_OE        = oe_reg;
	assign RD_STROBE      = rd_reg;
	assign WR_STROBE      = wr_reg;
	assign SYNC           = sync_reg;
	assign ZERO_FLAG      = z_reg;
	assign SIGN_FLAG      = s_reg;
	assign PARITY_FLAG    = p_reg;
	assign CARRY_FLAG     = cy_reg;
	assign AUX_CARRY_FLAG = ac_reg;
	assign IRQ_ENABLE     = irq_en_reg;

	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);

	fetch_pc_a: assert property (in_m1 && at_t2 && !jmp_go_reg |=>
		pc_reg == $past(pc_reg) + 16'h0001) else $error("pc not bumped");
	op_latch_a: assert property (in_m1 && at_t3 |=>
		opcode_reg == $past(DATA_IN)) else $error("opcode not latched");
	cmp_flags_a: assert property (in_m2 && at_t3 && is_cpi |=>
		##2 (cy_reg == (act_reg < temp_reg)) &&
		(z_reg == (act_reg == temp_reg))) else $error("compare flags");
	cmp_len_a: assert property (in_m2 && at_t3 && is_cpi |->
		icnt_reg == `CEJ_CLK_CPI - 4'h1 ##1 SYNC && in_m1)
		else $error("compare length");
	daa_lo_a: assert property (in_m1 && at_t4 && is_daa |->
		wda[3:0] == rda[3:0] + ((rda[3:0] > 4'h9 || ac_reg) ? 4'h6 : 4'h0)
		##1 ac_reg == ($past(rda[3:0]) > 4'h9)) else $error("bcd low fix");
	daa_hi_a: assert property (in_m1 && at_t4 && is_daa |=>
		cy_reg == ($past(cy_reg) || $past(rda) > 8'h99))
		else $error("bcd high fix");
	daa_len_a: assert property (in_m1 && at_t4 && is_daa |=>
		SYNC && in_m1 && icnt_reg == 4'h0) else $error("adjust length");
	reg_wb_a: assert property (in_m1 && at_t5 && is_idr |->
		we_a && wda == (is_dec ? temp_reg - 8'h01 : temp_reg + 8'h01)
		##1 SYNC) else $error("register write back");
	reg_inc_a: assert property (in_m1 && at_t4 && is_idr |=>
		temp_reg == $past(rda) && at_t5) else $error("operand latch");
	mem_wr_a: assert property (in_m3 && at_t2 && is_idm |->
		WR_STROBE && DATA_OE && ADDR == pair_val && DATA_OUT ==
		(is_dec ? temp_reg - 8'h01 : temp_reg + 8'h01))
		else $error("memory write back");
	mem_len_a: assert property (in_m3 && at_t3 && is_idm |->
		icnt_reg == `CEJ_CLK_RMW - 4'h1) else $error("rmw length");
	keep_cy_a: assert property ((in_m1 && at_t5 && is_idr) ||
		(in_m2 && at_t3 && is_idm) |=> $stable(cy_reg))
		else $error("carry touched");
	pair_dec_a: assert property (in_m1 && at_t5 && is_dcx |->
		we_a && we_b && {wda, wdb} == pair_val - 16'h0001 ##1
		$stable({z_reg, s_reg, p_reg, cy_reg, ac_reg}))
		else $error("pair decrement");
	irq_off_a: assert property (in_m1 && at_t4 && is_di |=>
		!IRQ_ENABLE && SYNC) else $error("irq off");
	irq_on_a: assert property (in_m1 && at_t4 && is_ei |=>
		IRQ_ENABLE && SYNC) else $error("irq on");
	jcc_test_a: assert property (in_m1 && at_t4 && is_jcc |=>
		jmp_go_reg == ($past(field_a == 2'b00 ? ZERO_FLAG :
		(field_a == 2'b01 ? CARRY_FLAG : (field_a == 2'b10 ? PARITY_FLAG :
		SIGN_FLAG))) == sense_bit)) else $error("jump condition");
	jcc_pc_a: assert property (in_m3 && at_t3 && is_jcc &&
		jmp_go_reg |-> icnt_reg == `CEJ_CLK_JUMP - 4'h1 ##1
		ADDR == wz_reg ##2 pc_reg == wz_reg + 16'h0001)
		else $error("jump target");

	cpi_c: cover property (cmp_apply);
	jump_c: cover property (in_m1 && at_t2 && jmp_go_reg);
	rmw_c: cover property (in_m3 && at_t3 && is_idm);
	daa_c: cover property (in_m1 && at_t4 && is_daa && rda > 8'h99);
endmodule

// ==== rtl/cej_consts.svh ====
// Purpose: Shared constants of the instruction execution sequencer.
// Assumes: Included by its bare name from every design file that needs it.
// Notes:   Opcodes, field codes, register indices and clock counts.
`ifndef CEJ_CONSTS_SVH
`define CEJ_CONSTS_SVH

`define CEJ_OP_CMP_IMM  8'hfe
`define CEJ_OP_DEC_ADJ  8'h27
`define CEJ_OP_IRQ_OFF  8'hf3
`define CEJ_OP_IRQ_ON   8'hfb
`define CEJ_FLD_MEM     3'h6
`define CEJ_IDX_H       4'h4
`define CEJ_IDX_L       4'h5
`define CEJ_IDX_A       4'h7
`define CEJ_IDX_SPH     4'h8
`define CEJ_PC_RST      16'h0000
`define CEJ_BCD_NINE    4'h9
`define CEJ_FIX_LO      8'h06
`define CEJ_FIX_HI      8'h60
`define CEJ_CLK_CPI     4'h7
`define CEJ_CLK_RMW     4'ha
`define CEJ_CLK_JUMP    4'ha

`endif

// ==== rtl/cej_pkg.sv ====
// Purpose: Types of the instruction execution sequencer.
// Assumes: Nothing.
// Notes:   Clock state, machine cycle and arithmetic operation codes.
package cej_pkg;

	typedef enum logic [2:0] {
		CEJ_T1 = 3'b000,
		CEJ_T2 = 3'b001,
		CEJ_T3 = 3'b010,
		CEJ_T4 = 3'b011,
		CEJ_T5 = 3'b100
	} cej_tstate_e;

	typedef enum logic [1:0] {
		CEJ_M1 = 2'b00,
		CEJ_M2 = 2'b01,
		CEJ_M3 = 2'b10
	} cej_mcycle_e;

	typedef enum logic [1:0] {
		CEJ_ALU_INC = 2'b00,
		CEJ_ALU_DEC = 2'b01,
		CEJ_ALU_CMP = 2'b10,
		CEJ_ALU_DAA = 2'b11
	} cej_aluop_e;

endpackage

// ==== rtl/cej_regfile.sv ====
// Purpose: Working registers, two registered read ports, two write ports.
// Assumes: Writes to the same entry on both ports never coincide.
// Notes:   Read data appear one clock after the address.
module cej_regfile #(
	parameter int DW = 8,
	parameter int N  = 10
) (
	// Clock and reset
	input  wire logic          clk,
	input  wire logic          rst_n,
	// Read ports
	input  wire logic [3:0]    ra,
	input  wire logic [3:0]    rb,
	output logic      [DW-1:0] rda_reg,
	output logic      [DW-1:0] rdb_reg,
	// Write ports
	input  wire logic          we_a,
	input  wire logic [3:0]    wa,
	input  wire logic [DW-1:0] wda,
	input  wire logic          we_b,
	input  wire logic [3:0]    wb,
	input  wire logic [DW-1:0] wdb
);
	logic [DW-1:0] mem_reg [N];

	for (genvar i = 0; i < N; i++) begin : g_ent
		wire hit_a = we_a && (wa == 4'(i));
		wire hit_b = we_b && (wb == 4'(i));
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n)
				mem_reg[i] <= '0;
			else if (hit_a)
				mem_reg[i] <= wda;
			else if (hit_b)
				mem_reg[i] <= wdb;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rda_reg <= '0;
			rdb_reg <= '0;
		end else begin
			rda_reg <= mem_reg[ra];
			rdb_reg <= mem_reg[rb];
		end
	end
endmodule

// ==== rtl/cej_alu.sv ====
// Purpose: Byte arithmetic for increment, decrement, compare and BCD fix.
// Assumes: Purely combinational; the caller registers what it keeps.
// Notes:   Parity is set for an even count of ones.
`include "cej_consts.svh"
module cej_alu (
	// Operation
	input  wire cej_pkg::cej_aluop_e op,
	input  wire logic [7:0]          a,
	input  wire logic [7:0]          b,
	input  wire logic                cy_in,
	input  wire logic                ac_in,
	// Result
	output logic      [7:0]          res,
	output logic                     z,
	output logic                     s,
	output logic                     p,
	output logic                     cy,
	output logic                     ac
);
	wire       lo_fix = (a[3:0] > `CEJ_BCD_NINE) || ac_in;
	wire       hi_fix = (a[7:4] > `CEJ_BCD_NINE) || cy_in ||
		((a[7:4] >= `CEJ_BCD_NINE) && (a[3:0] > `CEJ_BCD_NINE));
	wire [7:0] corr = (lo_fix ? `CEJ_FIX_LO : 8'h00) |
		(hi_fix ? `CEJ_FIX_HI : 8'h00);
	wire [4:0] lo_sum = {1'b0, a[3:0]} + {1'b0, corr[3:0]};
	wire [4:0] cmp_lo = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;

	always_comb begin
		res = a;
		cy  = cy_in;
		ac  = ac_in;
		unique case (op)
			cej_pkg::CEJ_ALU_INC: begin
				res = a + 8'h01;
				ac  = (a[3:0] == 4'hf);
			end
			cej_pkg::CEJ_ALU_DEC: begin
				res = a - 8'h01;
				ac  = (a[3:0] != 4'h0);
			end
			cej_pkg::CEJ_ALU_CMP: begin
				res = a - b;
				cy  = (a < b);
				ac  = cmp_lo[4];
			end
			cej_pkg::CEJ_ALU_DAA: begin
				res = a + corr;
				cy  = cy_in || hi_fix;
				ac  = lo_sum[4];
			end
		endcase
		z = (res == 8'h00);
		s = res[7];
		p = ~^res;
	end
endmodule

// ==== verif/cej_mem_model.sv ====
// Purpose: Program and data memory on the far side of the sequencer bus.
// Assumes: Reads are served while RD_STROBE is high, with no wait states.
// Notes:   Only the low address byte selects a location; the last write
//          address is kept so the bench can see where a write landed.
module cej_mem_model (
	// Clock
	input  wire logic        CLK_SYS,
	// Bus
	input  wire logic [15:0] ADDR,
	output logic      [7:0]  DATA_IN,
	input  wire logic [7:0]  DATA_OUT,
	input  wire logic        DATA_OE,
	input  wire logic        RD_STROBE,
	input  wire logic        WR_STROBE
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [7:0]  m [256];
	logic [15:0] wa = 16'h0000;

	initial DATA_IN = 8'h00;

	// A released bus flips every cycle, so a stale byte is never taken.
	always @(negedge CLK_SYS) begin
		if (RD_STROBE)
			DATA_IN <= m[ADDR[7:0]];
		else
			DATA_IN <= ~DATA_IN;
	end

	always @(posedge CLK_SYS) begin
		if (WR_STROBE && DATA_OE) begin
			m[ADDR[7:0]] <= DATA_OUT;
			wa <= ADDR;
		end
	end
endmodule

// ==== verif/tb.sv ====
// Purpose: Self-checking bench for the execution sequencer.
// Assumes: Inputs change at the falling clock edge.
// Notes:   One program runs from address zero; each step checks the fetch
//          address and the clock count; all but the jumps and the irq on step also check the flags left behind.
module tb;
	timeunit 1ns;
	timeprecision 100ps;

	logic        CLK_SYS = 1'b0;
	logic        RST_N   = 1'b0;
	logic [15:0] ADDR;
	logic [7:0]  DATA_IN;
	logic [7:0]  DATA_OUT;
	logic        DATA_OE;
	logic        RD_STROBE;
	logic        WR_STROBE;
	logic        SYNC;
	logic        ZERO_FLAG;
	logic        SIGN_FLAG;
	logic        PARITY_FLAG;
	logic        CARRY_FLAG;
	logic        AUX_CARRY_FLAG;
	logic        IRQ_ENABLE;
	int          n_errors = 0;
	int          compares = 0;
	logic [4:0]  fl;
	logic [119:0] prog = 120'h3d272b34352c34fe6500fbf3ca2000;

	assign fl = {ZERO_FLAG, SIGN_FLAG, PARITY_FLAG, CARRY_FLAG,
		AUX_CARRY_FLAG};

	cej_exec dut (
		.CLK_SYS        (CLK_SYS),
		.RST_N          (RST_N),
		.ADDR           (ADDR),
		.DATA_IN        (DATA_IN),
		.DATA_OUT       (DATA_OUT),
		.DATA_OE        (DATA_OE),
		.RD_STROBE      (RD_STROBE),
		.WR_STROBE      (WR_STROBE),
		.SYNC           (SYNC),
		.ZERO_FLAG      (ZERO_FLAG),
		.SIGN_FLAG      (SIGN_FLAG),
		.PARITY_FLAG    (PARITY_FLAG),
		.CARRY_FLAG     (CARRY_FLAG),
		.AUX_CARRY_FLAG (AUX_CARRY_FLAG),
		.IRQ_ENABLE     (IRQ_ENABLE)
	);

	cej_mem_model mem (
		.CLK_SYS   (CLK_SYS),
		.ADDR      (ADDR),
		.DATA_IN   (DATA_IN),
		.DATA_OUT  (DATA_OUT),
		.DATA_OE   (DATA_OE),
		.RD_STROBE (RD_STROBE),
		.WR_STROBE (WR_STROBE)
	);

	initial begin
		forever #20 CLK_SYS = ~CLK_SYS;
	end

	task automatic chk(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Flags are {zero, sign, parity, carry, aux}; a clear mask bit skips one.
	task automatic chk_flags(input logic [4:0] exp, input logic [4:0] msk);
		compares++;
		if ((fl & msk) !== (exp & msk)) begin
			n_errors++;
			$display("CHECK FAILED flags expected %b seen %b", exp & msk,
				fl & msk);
		end
	endtask

	// Called in the T1 of a fetch; returns in the T1 of the next fetch.
	task automatic instr(input logic [15:0] pc, input int nclk);
		chk("fetch address", pc, ADDR);
		@(negedge CLK_SYS);
		chk("read strobe", 16'h0001, {15'h0000, RD_STROBE});
		repeat (nclk - 1) @(negedge CLK_SYS);
		chk("next sync", 16'h0001, {15'h0000, SYNC});
	endtask

	task automatic finish_test();
		$display("compares %0d n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial begin
		repeat (2000) @(posedge CLK_SYS);
		n_errors++;
		finish_test();
	end

	initial begin
		for (int i = 0; i < 256; i++)
			mem.m[i] = 8'h00;
		for (int i = 0; i < 15; i++)
			mem.m[i] = prog[8*(14-i) +: 8];
		mem.m[8'h20] = 8'hd2;
		mem.m[8'h21] = 8'h40;
		mem.m[8'h40] = 8'he2;
		mem.m[8'h43] = 8'hfa;
		mem.m[8'hff] = 8'h7f;
		repeat (5) @(negedge CLK_SYS);
		RST_N = 1'b1;
		instr(16'h0000, 5);
		chk_flags(5'b01100, 5'b11111);
		instr(16'h0001, 4);
		chk_flags(5'b00111, 5'b11111);
		instr(16'h0002, 5);
		chk_flags(5'b00111, 5'b11111);
		instr(16'h0003, 10);
		chk("write address", 16'hffff, mem.wa);
		chk("memory byte", 16'h0080, {8'h00, mem.m[8'hff]});
		chk_flags(5'b01011, 5'b11111);
		instr(16'h0004, 10);
		chk("memory byte", 16'h007f, {8'h00, mem.m[8'hff]});
		chk_flags(5'b00010, 5'b11111);
		instr(16'h0005, 5);
		chk_flags(5'b10111, 5'b11111);
		instr(16'h0006, 10);
		chk("write address", 16'hff00, mem.wa);
		chk("memory byte", 16'h003e, {8'h00, mem.m[8'h00]});
		chk_flags(5'b00010, 5'b11111);
		$display("test arithmetic done");
		instr(16'h0007, 7);
		chk_flags(5'b00010, 5'b11111);
		instr(16'h0009, 4);
		chk_flags(5'b10101, 5'b11111);
		instr(16'h000a, 4);
		chk("irq enable", 16'h0001, {15'h0000, IRQ_ENABLE});
		instr(16'h000b, 4);
		chk("irq enable", 16'h0000, {15'h0000, IRQ_ENABLE});
		chk_flags(5'b10101, 5'b11111);
		$display("test compare and irq done");
		instr(16'h000c, 10);
		instr(16'h0020, 10);
		instr(16'h0040, 10);
		instr(16'h0043, 10);
		chk("fetch address", 16'h0046, ADDR);
		$display("test jumps done");
		finish_test();
	end
endmodule
